/* File: inc/oh_adapt_pkg.sv */
// constants and carriers for the 64 kbit/s overhead byte adapter
package oh_adapt_pkg;
  // ==========================================
  // octet and store sizing
  localparam int OCTET_BITS = 8;
  localparam int STORE_ADDR_BITS = 2;
  localparam int STORE_DEPTH = 1 << STORE_ADDR_BITS;
  // wander in ns; one 64k bit is 15625 ns, so two bits of slack cover it
  localparam int WANDER_NS = 18000;
  localparam int BIT_NS = 15625;
  localparam int WANDER_BITS = (WANDER_NS + BIT_NS - 1) / BIT_NS;
  // positive slip when the store holds this many octets or more
  localparam logic [STORE_ADDR_BITS:0] STORE_HIGH_MARK = 3'h3;
  // ==========================================
  // rates and times
  localparam int CLK_HZ = 20000000;
  localparam int LINK_HZ = 6250000;
  localparam int CLIENT_BIT_HZ = 64000;
  localparam int ALARM_MS = 1;
  localparam int ALARM_CYCLES = CLK_HZ / 1000 * ALARM_MS;
  localparam int AIS_PPM = 100;
  localparam int USER_AIS_PPM = 100;
  localparam int TICK_MAX_GAP = (LINK_HZ + CLIENT_BIT_HZ - 1) / CLIENT_BIT_HZ;
  localparam logic [7:0] ONES_OCTET = 8'hff;
  localparam logic [2:0] LAST_BIT = 3'h7;
  // ==========================================
  // carriers
  typedef struct packed {
    logic [7:0] data;
    logic frame_start;
    logic byte_slot;
  } path_in_type;
  typedef struct packed {
    logic [7:0] data;
    logic write;
  } path_out_type;
  typedef enum logic [1:0] {SLIP_NONE, SLIP_POS, SLIP_NEG} slip_type;
endpackage

/* File: logic/path_overhead_64k_channel_adapt.sv */
// adapter of a 64 kbit/s client into the overhead byte of a 34 Mbit/s path
`timescale 1ns/1ns
`default_nettype none
module path_overhead_64k_channel_adapt #(
  parameter int link_hz = oh_adapt_pkg::LINK_HZ,
  parameter int bit_hz = oh_adapt_pkg::CLIENT_BIT_HZ,
  parameter int user_ais_ppm = oh_adapt_pkg::USER_AIS_PPM
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic link_clk,
  input wire oh_adapt_pkg::path_in_type path_in,
  input wire logic trail_fail_in,
  output oh_adapt_pkg::path_out_type path_out,
  input wire logic gen_src_active,
  input wire logic gen_src_bit,
  input wire logic gen_src_bit_en,
  input wire logic gen_src_octet_start,
  input wire logic gen_snk_active,
  output logic gen_snk_data,
  output logic gen_snk_bit_tick,
  output logic gen_snk_octet_start,
  output logic gen_snk_alarm,
  input wire logic user_src_active,
  input wire logic [7:0] user_src_octet,
  output logic user_src_clock,
  input wire logic user_snk_active,
  output logic [7:0] user_snk_octet,
  output logic user_snk_clock,
  output logic user_snk_frame_start,
  output logic client_fail_out
);
  import oh_adapt_pkg::*;

  localparam int AW = STORE_ADDR_BITS;

  // ==========================================
  // elastic store, write side on link_clk
  logic [7:0] store [STORE_DEPTH];
  logic [7:0] wr_shift;
  logic [2:0] wr_bitcnt;
  logic [AW:0] wptr_bin;
  logic [AW:0] wptr_gray;
  logic [AW:0] rptr_gray;
  logic [AW:0] rptr_gray_s1;
  logic [AW:0] rptr_gray_s2;
  logic [AW:0] rptr_seen;
  logic [AW:0] next_wptr;
  logic store_full;

  function automatic logic [AW:0] gray_to_bin(input logic [AW:0] g);
    logic [AW:0] b;
    b = '0;
    b[AW] = g[AW];
    for (int i = AW - 1; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  assign next_wptr = wptr_bin + (AW + 1)'(1);
  assign rptr_seen = gray_to_bin(rptr_gray_s2);
  assign store_full = (wptr_bin - rptr_seen) == (AW + 1)'(STORE_DEPTH);

  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      rptr_gray_s1 <= '0;
      rptr_gray_s2 <= '0;
    end else begin
      rptr_gray_s1 <= rptr_gray;
      rptr_gray_s2 <= rptr_gray_s1;
    end
  end

  // octet assembly from the serial client, msb first
  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      wr_shift <= '0;
      wr_bitcnt <= '0;
    end else if (gen_src_bit_en) begin
      wr_shift <= {wr_shift[6:0], gen_src_bit};
      wr_bitcnt <= gen_src_octet_start ? 3'h1 : wr_bitcnt + 3'h1;
    end
  end

  // a full store drops the octet; the read side slips to recover
  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      wptr_bin <= '0;
      wptr_gray <= '0;
    end else if (gen_src_bit_en && wr_bitcnt == LAST_BIT && !store_full) begin
      wptr_bin <= next_wptr;
      wptr_gray <= next_wptr ^ (next_wptr >> 1);
    end
  end

  always_ff @(posedge link_clk) begin
    if (gen_src_bit_en && wr_bitcnt == LAST_BIT && !store_full) begin
      store[wptr_bin[AW-1:0]] <= {wr_shift[6:0], gen_src_bit};
    end
  end

  // ==========================================
  // elastic store, read side on clk
  logic [AW:0] wptr_gray_s1;
  logic [AW:0] wptr_gray_s2;
  logic [AW:0] wptr_seen;
  logic [AW:0] rptr_bin;
  logic [AW:0] store_fill;
  logic [7:0] last_octet;
  slip_type slip;
  logic [AW:0] next_rptr;
  logic [7:0] next_octet;

  assign wptr_seen = gray_to_bin(wptr_gray_s2);
  assign store_fill = wptr_seen - rptr_bin;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wptr_gray_s1 <= '0;
      wptr_gray_s2 <= '0;
    end else begin
      wptr_gray_s1 <= wptr_gray;
      wptr_gray_s2 <= wptr_gray_s1;
    end
  end

  // depth covers WANDER_BITS of drift either way around the centre
  always_comb begin
    slip = SLIP_NONE;
    next_rptr = rptr_bin + (AW + 1)'(1);
    next_octet = store[rptr_bin[AW-1:0]];
    if (store_fill == '0) begin
      slip = SLIP_NEG;
      next_rptr = rptr_bin;
      next_octet = last_octet;
    end else if (store_fill >= STORE_HIGH_MARK) begin
      slip = SLIP_POS;
      next_rptr = rptr_bin + (AW + 1)'(2);
      next_octet = store[next_rptr[AW-1:0] - AW'(1)];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rptr_bin <= '0;
      rptr_gray <= '0;
      last_octet <= ONES_OCTET;
    end else if (path_in.byte_slot && gen_src_active) begin
      rptr_bin <= next_rptr;
      rptr_gray <= next_rptr ^ (next_rptr >> 1);
      last_octet <= next_octet;
    end
  end

  // ==========================================
  // path byte writers; generic source wins if both are active
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      path_out <= '0;
    end else begin
      path_out.write <= path_in.byte_slot && (gen_src_active || user_src_active);
      if (path_in.byte_slot && gen_src_active) begin
        path_out.data <= next_octet;
      end else if (path_in.byte_slot && user_src_active) begin
        path_out.data <= user_src_octet;
      end
    end
  end

  // one octet request per frame, ahead of the byte slot
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      user_src_clock <= 1'b0;
    end else begin
      user_src_clock <= path_in.frame_start && user_src_active;
    end
  end

  // ==========================================
  // user sink, byte parallel on clk
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      user_snk_octet <= ONES_OCTET;
      user_snk_clock <= 1'b0;
      user_snk_frame_start <= 1'b0;
      client_fail_out <= 1'b0;
    end else begin
      client_fail_out <= trail_fail_in;
      user_snk_clock <= path_in.byte_slot;
      user_snk_frame_start <= path_in.frame_start;
      if (!user_snk_active || trail_fail_in) begin
        user_snk_octet <= ONES_OCTET;
      end else if (path_in.byte_slot) begin
        user_snk_octet <= path_in.data;
      end
    end
  end

  // ==========================================
  // generic sink, latch on clk
  logic [7:0] snk_latch;
  logic snk_toggle;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      snk_latch <= ONES_OCTET;
      snk_toggle <= 1'b0;
    end else if (path_in.byte_slot && gen_snk_active) begin
      snk_latch <= path_in.data;
      snk_toggle <= !snk_toggle;
    end
  end

  // ==========================================
  // generic sink readout on link_clk
  logic [2:0] tog_sync;
  logic [1:0] active_sync;
  logic [1:0] fail_sync;
  logic [7:0] snk_pending;
  logic [7:0] snk_shift;
  logic [2:0] rd_bitcnt;
  logic [23:0] phase_acc;
  logic bit_tick;
  logic snk_ones;

  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      tog_sync <= '0;
      active_sync <= '0;
      fail_sync <= '0;
    end else begin
      tog_sync <= {tog_sync[1:0], snk_toggle};
      active_sync <= {active_sync[0], gen_snk_active};
      fail_sync <= {fail_sync[0], trail_fail_in};
    end
  end

  // latch is stable once its toggle has crossed
  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      snk_pending <= ONES_OCTET;
    end else if (tog_sync[2] != tog_sync[1]) begin
      snk_pending <= snk_latch;
    end
  end

  // non-integer division: average rate exact, jitter one link cycle
  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      phase_acc <= '0;
      bit_tick <= 1'b0;
    end else if (phase_acc + 24'(bit_hz) >= 24'(link_hz)) begin
      phase_acc <= phase_acc + 24'(bit_hz) - 24'(link_hz);
      bit_tick <= 1'b1;
    end else begin
      phase_acc <= phase_acc + 24'(bit_hz);
      bit_tick <= 1'b0;
    end
  end

  assign snk_ones = fail_sync[1] || !active_sync[1];

  // ones replace data at the next bit, far inside the 1 ms allowance
  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      snk_shift <= ONES_OCTET;
      rd_bitcnt <= '0;
      gen_snk_data <= 1'b1;
      gen_snk_bit_tick <= 1'b0;
      gen_snk_octet_start <= 1'b0;
      gen_snk_alarm <= 1'b0;
    end else begin
      gen_snk_alarm <= fail_sync[1];
      gen_snk_bit_tick <= bit_tick;
      gen_snk_octet_start <= bit_tick && rd_bitcnt == '0;
      if (bit_tick) begin
        rd_bitcnt <= rd_bitcnt + 3'h1;
        if (rd_bitcnt == '0) begin
          snk_shift <= {snk_pending[6:0], 1'b1};
          gen_snk_data <= snk_ones ? 1'b1 : snk_pending[7];
        end else begin
          snk_shift <= {snk_shift[6:0], 1'b1};
          gen_snk_data <= snk_ones ? 1'b1 : snk_shift[7];
        end
      end
    end
  end

  // ==========================================
  // checks
  int unsigned tick_gap;
  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      tick_gap <= 0;
    end else begin
      tick_gap <= bit_tick ? 0 : tick_gap + 1;
    end
  end

  sequence slot_seen;
    path_in.byte_slot;
  endsequence

  a_src_inactive_quiet: assert property (@(posedge clk) disable iff (reset)
    slot_seen and !gen_src_active && !user_src_active |=> !path_out.write)
    else $error("byte written while sources inactive");
  a_src_active_write: assert property (@(posedge clk) disable iff (reset)
    slot_seen and gen_src_active |=> path_out.write)
    else $error("active source missed its slot");
  a_neg_slip_repeat: assert property (@(posedge clk) disable iff (reset)
    slot_seen and gen_src_active && slip == SLIP_NEG |=>
      path_out.data == $past(last_octet) && $stable(rptr_bin))
    else $error("negative slip did not repeat octet");
  a_pos_slip_skip: assert property (@(posedge clk) disable iff (reset)
    slot_seen and gen_src_active && slip == SLIP_POS |=> rptr_bin == $past(rptr_bin) + 2'h2)
    else $error("positive slip did not skip one octet");
  a_user_byte_insert: assert property (@(posedge clk) disable iff (reset)
    slot_seen and !gen_src_active && user_src_active |=> path_out.data == $past(user_src_octet))
    else $error("user octet not inserted");
  a_user_fail_follow: assert property (@(posedge clk) disable iff (reset)
    ##1 client_fail_out == $past(trail_fail_in))
    else $error("client fail does not follow trail fail");
  a_user_sink_ones: assert property (@(posedge clk) disable iff (reset)
    !user_snk_active ##1 !user_snk_active |-> user_snk_octet == ONES_OCTET)
    else $error("inactive user sink not all ones");
  a_sink_latch: assert property (@(posedge clk) disable iff (reset)
    slot_seen and gen_snk_active |=> snk_latch == $past(path_in.data) && $changed(snk_toggle))
    else $error("sink octet not latched");
  a_tick_rate: assert property (@(posedge link_clk) disable iff (reset)
    tick_gap <= TICK_MAX_GAP)
    else $error("64 kHz readout tick too slow");
  a_alarm_ones: assert property (@(posedge link_clk) disable iff (reset)
    fail_sync[1] ##1 fail_sync[1] && gen_snk_bit_tick |-> gen_snk_data)
    else $error("alarm did not force ones");
endmodule
`default_nettype wire

/* File: sim/path_framer_model.sv */
// path framer and 64 kbit/s client model facing the adapter
`timescale 1ns/1ns
`default_nettype none
module path_framer_model #(
  parameter int frame_cycles = 2500,
  parameter int bit_cycles = 98
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic link_clk,
  input wire logic [7:0] send_octet,
  input wire logic [7:0] client_octet,
  input wire logic client_pause,
  output oh_adapt_pkg::path_in_type path_in,
  output logic gen_src_bit,
  output logic gen_src_bit_en,
  output logic gen_src_octet_start
);
  import oh_adapt_pkg::*;
  int pos;
  int lpos;
  logic [2:0] bit_idx;
  // ==========================================
  // framer
  // outside the slot the byte carries a moving pattern, never a stale copy
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pos <= 0;
      path_in <= '0;
    end else begin
      pos <= (pos == frame_cycles - 1) ? 0 : pos + 1;
      path_in.frame_start <= (pos == 0);
      path_in.byte_slot <= (pos == 10);
      path_in.data <= (pos == 10) ? send_octet : 8'(pos);
    end
  end
  // ==========================================
  // client
  // slightly slow client, so the store now and then repeats an octet
  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      lpos <= 0;
      bit_idx <= 3'h0;
      gen_src_bit_en <= 1'b0;
      gen_src_octet_start <= 1'b0;
      gen_src_bit <= 1'b0;
    end else begin
      lpos <= (lpos == bit_cycles - 1) ? 0 : lpos + 1;
      // a paused client keeps its bit position, so octets stay aligned on resume
      gen_src_bit_en <= (lpos == 0) && !client_pause;
      gen_src_octet_start <= (lpos == 0) && !client_pause && (bit_idx == 3'h0);
      gen_src_bit <= (lpos == 0) ? client_octet[3'h7 - bit_idx] : ~gen_src_bit;
      if (lpos == 0 && !client_pause) begin
        bit_idx <= bit_idx + 3'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: sim/path_overhead_64k_channel_adapt_tb.sv */
// self-checking bench of the overhead byte adapter
`timescale 1ns/1ns
`default_nettype none
module path_overhead_64k_channel_adapt_tb;
  import oh_adapt_pkg::*;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic reset = 1'b1;
  path_in_type path_in;
  path_out_type path_out;
  logic trail_fail_in = 1'b0;
  logic gen_src_active = 1'b0;
  logic gen_src_bit, gen_src_bit_en, gen_src_octet_start;
  logic gen_snk_active = 1'b0;
  logic gen_snk_data, gen_snk_bit_tick, gen_snk_octet_start, gen_snk_alarm;
  logic user_src_active = 1'b0;
  logic [7:0] user_src_octet = 8'h00;
  logic user_src_clock;
  logic user_snk_active = 1'b0;
  logic [7:0] user_snk_octet;
  logic user_snk_clock, user_snk_frame_start, client_fail_out;
  logic [7:0] send_octet = 8'h00;
  logic [7:0] client_octet = 8'h5a;
  logic client_pause = 1'b0;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  path_framer_model i_model (.clk(clk), .reset(reset), .link_clk(link_clk),
    .send_octet(send_octet), .client_octet(client_octet), .client_pause(client_pause),
    .path_in(path_in),
    .gen_src_bit(gen_src_bit), .gen_src_bit_en(gen_src_bit_en),
    .gen_src_octet_start(gen_src_octet_start));
  path_overhead_64k_channel_adapt i_dut (.clk(clk), .reset(reset), .link_clk(link_clk),
    .path_in(path_in), .trail_fail_in(trail_fail_in), .path_out(path_out),
    .gen_src_active(gen_src_active), .gen_src_bit(gen_src_bit),
    .gen_src_bit_en(gen_src_bit_en), .gen_src_octet_start(gen_src_octet_start),
    .gen_snk_active(gen_snk_active), .gen_snk_data(gen_snk_data),
    .gen_snk_bit_tick(gen_snk_bit_tick), .gen_snk_octet_start(gen_snk_octet_start),
    .gen_snk_alarm(gen_snk_alarm), .user_src_active(user_src_active),
    .user_src_octet(user_src_octet), .user_src_clock(user_src_clock),
    .user_snk_active(user_snk_active), .user_snk_octet(user_snk_octet),
    .user_snk_clock(user_snk_clock), .user_snk_frame_start(user_snk_frame_start),
    .client_fail_out(client_fail_out));
  always #25 clk = ~clk;
  // 160 ns link clock; its edges never meet the path clock rising edges
  always #80 link_clk = ~link_clk;
  // ==========================================
  // helpers
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // returns just after the edge that answers a frame start or a byte slot
  task automatic wait_on(input bit slot);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (!(slot ? path_in.byte_slot : path_in.frame_start) && n < 3000);
    @(posedge clk);
    #1;
  endtask
  // one serial octet from the generic sink, msb first
  task automatic collect(output logic [7:0] v);
    int n;
    n = 0;
    do begin
      @(posedge link_clk);
      #1;
      n++;
    end while (!(gen_snk_bit_tick && gen_snk_octet_start) && n < 2000);
    v = {7'h0, gen_snk_data};
    for (int i = 1; i < 8; i++) begin
      n = 0;
      do begin
        @(posedge link_clk);
        #1;
        n++;
      end while (!gen_snk_bit_tick && n < 200);
      v = {v[6:0], gen_snk_data};
      check("tick gap", 8'h1, 8'(n == 97 || n == 98));
    end
  endtask
  // ==========================================
  // scenarios
  task automatic t_user_src();
    user_src_active = 1'b1;
    user_src_octet = 8'h3c;
    wait_on(1'b0);
    check("user src clock", 8'h1, 8'(user_src_clock));
    wait_on(1'b1);
    check("user write", 8'h1, 8'(path_out.write));
    check("user octet", 8'h3c, path_out.data);
    user_src_active = 1'b0;
    wait_on(1'b1);
    check("idle write", 8'h0, 8'(path_out.write));
  endtask
  task automatic t_user_snk();
    user_snk_active = 1'b1;
    send_octet = 8'ha5;
    wait_on(1'b1);
    check("user snk clock", 8'h1, 8'(user_snk_clock));
    check("user snk octet", 8'ha5, user_snk_octet);
    wait_on(1'b0);
    check("user snk frame", 8'h1, 8'(user_snk_frame_start));
    user_snk_active = 1'b0;
    wait_on(1'b1);
    check("inactive user octet", 8'hff, user_snk_octet);
    user_snk_active = 1'b1;
    trail_fail_in = 1'b1;
    @(posedge clk);
    #1;
    check("fail out", 8'h1, 8'(client_fail_out));
    wait_on(1'b1);
    check("user alarm octet", 8'hff, user_snk_octet);
    trail_fail_in = 1'b0;
    wait_on(1'b1);
    check("user restored", 8'ha5, user_snk_octet);
    check("fail cleared", 8'h0, 8'(client_fail_out));
  endtask
  task automatic t_gen_src();
    gen_src_active = 1'b1;
    repeat (6) wait_on(1'b1);
    check("gen write", 8'h1, 8'(path_out.write));
    check("gen octet", 8'h5a, path_out.data);
    user_src_active = 1'b1;
    wait_on(1'b1);
    check("gen wins", 8'h5a, path_out.data);
    // a stalled client drains the store; later slots must repeat the last octet
    client_pause = 1'b1;
    repeat (4) wait_on(1'b1);
    check("drained write", 8'h1, 8'(path_out.write));
    check("repeated octet", 8'h5a, path_out.data);
    client_pause = 1'b0;
    gen_src_active = 1'b0;
    user_src_active = 1'b0;
    wait_on(1'b1);
    check("gen idle", 8'h0, 8'(path_out.write));
  endtask
  task automatic t_gen_snk();
    logic [7:0] v;
    send_octet = 8'hc3;
    gen_snk_active = 1'b1;
    repeat (2) collect(v);
    check("sink octet", 8'hc3, v);
    @(posedge clk) #1 trail_fail_in = 1'b1;
    repeat (2) collect(v);
    check("alarm octet", 8'hff, v);
    check("alarm flag", 8'h1, 8'(gen_snk_alarm));
    @(posedge clk) #1 trail_fail_in = 1'b0;
    repeat (2) collect(v);
    check("restored octet", 8'hc3, v);
    check("alarm clear", 8'h0, 8'(gen_snk_alarm));
    @(posedge clk) #1 gen_snk_active = 1'b0;
    repeat (2) collect(v);
    check("inactive octet", 8'hff, v);
  endtask
  // ==========================================
  // run control
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 95000) begin
      bad_count++;
      $display("BAD cycle limit expected %0d seen %0d", 94999, cycles);
      wrap_up();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    #1 reset = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    t_user_src();
    t_user_snk();
    t_gen_src();
    t_gen_snk();
    wrap_up();
  end
endmodule
`default_nettype wire
